// ==== bench/pcf_fault_check_tb.sv ====
// bench for the protection fault checker: register bus driver and fault scenarios
// assumes pcf_pkg and pcf_fault_check compiled first; clk_en held high
`timescale 1ns/1ps
module pcf_fault_check_tb import pcf_pkg::*;;
	logic         ref_clk, reset_n, bus_lock, exc_valid, lk, ev;
	logic [7:0]   exc_vector;
	logic [31:0]  st, d;
	logic [1:0]   r;
	pcf_axi_req_t rq;
	pcf_axi_rsp_t rs;
	int           error_cnt, n_checks;
	int           lk_cnt, ev_cnt, lk0, ev0;
	localparam logic [8:0] PR = 9'h010, AC = 9'h100, PA = 9'h110;
	localparam logic [8:0] ME = 9'h040, IM = 9'h080, SK = 9'h020, D3 = 9'h00C;

	pcf_fault_check pcf_fault_check_i (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1),
		.s_axi_req(rq), .s_axi_rsp(rs), .bus_lock(bus_lock), .exc_valid(exc_valid),
		.exc_vector(exc_vector));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// lock and fault pulse are too short to catch by polling status
	always @(posedge ref_clk) begin
		if (bus_lock === 1'b1) lk_cnt <= lk_cnt + 1;
		if (exc_valid === 1'b1) ev_cnt <= ev_cnt + 1;
	end

	// ********
	// bus and compare tasks
	// ********
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
			error_cnt++;
		end
	endtask
	task automatic tmo;
		cmp("wait", 32'h0, 32'h1);
		finish_test();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge ref_clk);
		rq.awaddr <= {24'h000000, a};
		rq.wdata <= v;
		rq.awvalid <= 1'b1;
		rq.wvalid <= 1'b1;
		rq.bready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (!aw && rs.awready === 1'b1) begin
				aw = 1'b1;
				rq.awvalid <= 1'b0;
			end
			if (!w && rs.wready === 1'b1) begin
				w = 1'b1;
				rq.wvalid <= 1'b0;
			end
			if (rs.bvalid === 1'b1) begin
				r = rs.bresp;
				rq.bready <= 1'b0;
				return;
			end
		end
		tmo();
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		rq.araddr <= {24'h000000, a};
		rq.arvalid <= 1'b1;
		rq.rready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (rs.arready === 1'b1) rq.arvalid <= 1'b0;
			if (rs.rvalid === 1'b1) begin
				d = rs.rdata;
				r = rs.rresp;
				rq.rready <= 1'b0;
				return;
			end
		end
		tmo();
	endtask
	function automatic logic [31:0] mk(input pcf_op_t p, input logic [8:0] f, input logic [3:0] z);
		return {12'h000, z, 3'h0, f, p};
	endfunction
	// one request start to finish; st keeps status, d the clock count
	task automatic chk(input string s, input logic [1:0] c, input logic [31:0] q, o, l, m,
		input logic [7:0] v, input logic [7:0] k);
		wr(OFF_REQ, q);
		wr(OFF_OFFS, o);
		wr(OFF_LIMIT, l);
		wr(OFF_OPND, m);
		lk0 = lk_cnt;
		ev0 = ev_cnt;
		wr(OFF_CTRL, {29'h0, c, 1'b1});
		for (int n = 0; n < 60; n++) begin
			rd(OFF_STATUS);
			if (d[1:0] === 2'b10) begin
				st = d;
				lk = (lk_cnt != lk0);
				ev = (ev_cnt != ev0);
				rd(OFF_CYCLES);
				cmp({s, " fault"}, 32'(v != VEC_NONE), 32'(st[2]));
				cmp({s, " pulse"}, 32'(v != VEC_NONE), 32'(ev));
				if (v != VEC_NONE) begin
					cmp({s, " vec"}, 32'(v), 32'(st[15:8]));
					cmp({s, " pin"}, 32'(v), 32'(exc_vector));
				end
				if (k != 8'h00) cmp({s, " clks"}, 32'(k), 32'(d[7:0]));
				return;
			end
		end
		tmo();
	endtask

	// ********
	// scenarios
	// ********
	task automatic t_reg;
		rd(OFF_FLAGS);
		cmp("flags rst", RST_FLAGS, d);
		rd(8'h40);
		cmp("unmapped", 32'(RESP_SLVERR), 32'(r));
		wr(8'h40, '0);
		cmp("wr unmapped", 32'(RESP_SLVERR), 32'(r));
		wr(OFF_CYCLES, 32'hFF);
		cmp("ro wr resp", 32'(RESP_OKAY), 32'(r));
		rd(OFF_CYCLES);
		cmp("ro cycles", 32'h0, d);
		$display("t_reg done");
	endtask
	task automatic t_real;
		chk("task st", '0, mk(OP_STORE_TASK_REG, PA, '0), '0, '0, '0, VEC_UD, '0);
		chk("vrd real", '0, mk(OP_VERIFY_READ, PA, '0), '0, '0, '0, VEC_UD, '0);
		chk("msw st", '0, mk(OP_STORE_STATUS_WORD, PA, '0), '0, '0, '0, VEC_NONE, 8'h02);
		chk("dat end", '0, mk(OP_MEM_ACCESS, PA | ME, 4'h1), 32'hFFFE, '0, '0, VEC_NONE, '0);
		chk("dat over", '0, mk(OP_MEM_ACCESS, PA | ME, 4'h1), 32'hFFFF, '0, '0, VEC_GP, '0);
		chk("stk over", '0, mk(OP_MEM_ACCESS, PA | ME | SK, 4'h3), 32'hFFFE, '0, '0, VEC_SS, '0);
		chk("locked", '0, mk(OP_LOCKED, PA, '0), '0, '0, '0, VEC_NONE, '0);
		cmp("lock", 32'h1, 32'(lk));
		$display("t_real done");
	endtask
	task automatic t_mul;
		chk("m0", '0, mk(OP_MUL, PA, '0), '0, '0, '0, VEC_NONE, 8'h0C);
		chk("mneg", '0, mk(OP_MUL, PA, '0), '0, '0, 32'hFFFFFFF0, VEC_NONE, 8'h0D);
		chk("mmem", '0, mk(OP_MUL, PA | ME, '0), '0, '0, 32'h100, VEC_NONE, 8'h14);
		chk("mimm", '0, mk(OP_MUL, PA | IM, '0), '0, '0, 32'h00100000, VEC_NONE, 8'h1E);
		chk("mmi", '0, mk(OP_MUL, PA | ME | IM, '0), '0, '0, 32'h2, VEC_NONE, 8'h0E);
		$display("t_mul done");
	endtask
	task automatic t_prot;
		chk("pe on", '0, mk(OP_MOVE_CTRL_ZERO, PA, '0), '0, '0, 32'h1, VEC_NONE, '0);
		chk("cz lvl3", 2'h3, mk(OP_MOVE_CTRL_ZERO, PA, '0), '0, '0, '0, VEC_GP, '0);
		chk("msw ld", '0, mk(OP_LOAD_STATUS_WORD, PA, '0), '0, '0, '0, VEC_NONE, '0);
		rd(OFF_CTRL_ZERO);
		cmp("pe kept", 32'h1, d);
		chk("p0 l1", 2'h1, mk(OP_PRIV0, PA, '0), '0, '0, '0, VEC_GP, '0);
		chk("p0 l0", '0, mk(OP_PRIV0, PA, '0), '0, '0, '0, VEC_NONE, '0);
		chk("io l1", 2'h1, mk(OP_IO_CHECKED, PA, '0), '0, '0, '0, VEC_GP, '0);
		chk("iot l0", '0, mk(OP_IO_TIMED, PA, '0), '0, '0, '0, VEC_NONE, 8'h08);
		chk("iot l2", 2'h2, mk(OP_IO_TIMED, PA, '0), '0, '0, '0, VEC_NONE, 8'h18);
		chk("sg np", '0, mk(OP_SEG_LOAD, AC, '0), '0, '0, '0, VEC_NP, '0);
		chk("ss np", '0, mk(OP_SEG_LOAD, AC | SK, '0), '0, '0, '0, VEC_SS, '0);
		chk("sg pl", 2'h2, mk(OP_SEG_LOAD, PA, '0), '0, '0, '0, VEC_GP, '0);
		chk("far pl", '0, mk(OP_FAR_XFER, PA | D3, '0), '0, 32'hFF, '0, VEC_GP, '0);
		chk("far end", '0, mk(OP_FAR_XFER, PA, '0), 32'hFF, 32'hFF, '0, VEC_NONE, '0);
		chk("far out", '0, mk(OP_FAR_XFER, PA, '0), 32'h100, 32'hFF, '0, VEC_GP, '0);
		chk("m lim", '0, mk(OP_MEM_ACCESS, PA | ME, 4'h3), 32'hFD, 32'hFF, '0, VEC_GP, '0);
		chk("m acc", '0, mk(OP_MEM_ACCESS, PR | ME, '0), '0, 32'hFF, '0, VEC_GP, '0);
		chk("s lim", '0, mk(OP_MEM_ACCESS, PA | ME | SK, '0), 32'h100, 32'hFF, '0, VEC_SS, '0);
		chk("e acc", '0, mk(OP_COPROC_ESCAPE, PR | ME, '0), '0, 32'hFF, '0, VEC_GP, '0);
		chk("e stk", '0, mk(OP_COPROC_ESCAPE, PA | ME | SK, '0), 32'h100, 32'hFF, '0, VEC_SS, '0);
		chk("vrd r", '0, mk(OP_VERIFY_READ, PA | D3, '0), '0, '0, '0, VEC_NONE, 8'h0A);
		cmp("vrd zf", 32'h1, 32'(st[16]));
		cmp("vrd lock", 32'h1, 32'(lk));
		chk("vrd m", '0, mk(OP_VERIFY_READ, PA | ME | D3, '0), '0, '0, '0, VEC_NONE, 8'h0B);
		chk("vwr pl", 2'h3, mk(OP_VERIFY_WRITE, PA, '0), '0, '0, '0, VEC_NONE, '0);
		cmp("vwr zf", 32'h0, 32'(st[16]));
		$display("t_prot done");
	endtask
	task automatic t_flags;
		chk("fl l3", 2'h3, mk(OP_LOAD_FLAGS, PA, '0), '0, '0, 32'h00003202, VEC_NONE, '0);
		rd(OFF_FLAGS);
		cmp("fl kept", RST_FLAGS, d);
		chk("fl l0", '0, mk(OP_LOAD_FLAGS, PA, '0), '0, '0, 32'h00003202, VEC_NONE, '0);
		rd(OFF_FLAGS);
		cmp("fl set", 32'h00003202, d);
		chk("io ok", 2'h2, mk(OP_IO_CHECKED, PA, '0), '0, '0, '0, VEC_NONE, '0);
		chk("iot l3", 2'h3, mk(OP_IO_TIMED, PA, '0), '0, '0, '0, VEC_NONE, 8'h08);
		chk("fl l2", 2'h2, mk(OP_LOAD_FLAGS, PA, '0), '0, '0, 32'h00000002, VEC_NONE, '0);
		rd(OFF_FLAGS);
		cmp("fl if", 32'h00003002, d);
		$display("t_flags done");
	endtask

	initial begin
		rq = '0;
		rq.wstrb = 4'hF;
		reset_n = 1'b0;
		lk = 1'b0;
		ev = 1'b0;
		error_cnt = 0;
		n_checks = 0;
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_reg();
		t_real();
		t_mul();
		t_prot();
		t_flags();
		finish_test();
	end
endmodule

// ==== verilog/pcf_fault_check.sv ====
// protection fault checker: evaluates one instruction request per start
// assumes a single clock, synchronous active-low reset, AXI4-Lite register access
//
// How it works
// - protected-only ops fault six in real mode
// - real mode data beyond FFFFH faults thirteen
// - real mode stack overrun faults twelve
// - status word store allowed in real mode
// - multiply ends early by multiplier magnitude
// - multiply base count by operand form
// - implicitly locked ops assert bus lock
// - descriptor table accesses hold bus lock
// - protected limit or rights fault; stack limit twelve
// - segment load privilege, presence faults
// - cross-segment transfers obey privilege rules
// - most-privileged ops fault above level zero
// - checked io ops fault when privilege exceeds field
// - flags load guards interrupt, io, v86
// - status word load never clears protection
// - verify privilege failure clears zero flag
// - coprocessor operand checked before escape
// - transfer destination within code limit
// - two-count ops pick count by privilege
// - verify read invalid real, 10/11 protected
`timescale 1ns/1ps
module pcf_fault_check import pcf_pkg::*; #(
	parameter logic [7:0] DEF_CLKS     = 8'h02,
	parameter logic [7:0] IO_CLKS_LOW  = 8'h08,
	parameter logic [7:0] IO_CLKS_HIGH = 8'h18
) (
	input  wire logic   ref_clk,
	input  wire logic   reset_n,
	input  wire logic   clk_en,
	input  wire pcf_axi_req_t s_axi_req,
	output pcf_axi_rsp_t      s_axi_rsp,
	output logic        bus_lock,
	output logic        exc_valid,
	output logic [7:0]  exc_vector
);

	// ****************************************
	// parameter checks
	// ****************************************
	if (DEF_CLKS == 8'h00 || IO_CLKS_LOW == 8'h00 || IO_CLKS_HIGH == 8'h00) begin : g_bad_clks
		$error("clock counts must be at least one");
	end

	// ****************************************
	// state
	// ****************************************
	typedef enum logic {ST_IDLE, ST_RUN} pcf_phase_t;

	typedef struct packed {
		pcf_phase_t  phase;
		logic [7:0]  count;
		pcf_ctrl_t   ctrl;
		pcf_req_t    req;
		logic [31:0] offs;
		logic [31:0] limit;
		logic [31:0] opnd;
		logic [31:0] flags;
		logic        prot_en;
		pcf_status_t status;
		logic [7:0]  cycles;
		logic        p_fault;
		logic [7:0]  p_vec;
		logic        p_zf;
		logic [31:0] p_flags;
		logic        p_prot_en;
		logic        bus_lock;
		logic        exc_valid;
		logic [7:0]  exc_vector;
		logic        awready;
		logic        wready;
		logic        aw_got;
		logic        w_got;
		logic        aw_hi_ok;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} pcf_state_t;

	pcf_state_t st_reg;
	pcf_state_t st_next;
	logic       go;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction

	// smallest k with 2**k >= v; zero for v of zero or one
	function automatic logic [7:0] ceil_log2(input logic [31:0] v);
		logic [31:0] x;
		logic [7:0]  k;
		x = v - 32'h00000001;
		k = 8'h00;
		if (v > 32'h00000001) begin
			for (int i = 0; i < 32; i++) begin
				if (x[i]) begin
					k = 8'(i + 1);
				end
			end
		end
		return k;
	endfunction

	function automatic logic priv_ok(input logic [1:0] cp, input logic [1:0] rp,
		input logic [1:0] dp);
		return (dp >= cp) && (dp >= rp);
	endfunction

	// real mode passes the fixed limit and forces rights good
	function automatic logic [7:0] mem_check(input logic mem, input logic stack,
		input logic acc_ok, input logic [32:0] last, input logic [31:0] lim);
		if (!mem) begin
			return VEC_NONE;
		end else if (last > {1'b0, lim}) begin
			return stack ? VEC_SS : VEC_GP;
		end else if (!acc_ok) begin
			return VEC_GP;
		end
		return VEC_NONE;
	endfunction

	function automatic logic [33:0] read_reg(input pcf_state_t s, input logic [31:0] a);
		logic [31:0] d;
		logic [1:0]  r;
		d = 32'h00000000;
		r = RESP_OKAY;
		if (a[31:8] != 24'h000000) begin
			r = RESP_SLVERR;
		end else begin
			case (a[7:0])
				OFF_CTRL:      d = {s.ctrl.rsvd, s.ctrl.cur_priv, 1'b0};
				OFF_REQ:       d = s.req;
				OFF_OFFS:      d = s.offs;
				OFF_LIMIT:     d = s.limit;
				OFF_OPND:      d = s.opnd;
				OFF_FLAGS:     d = s.flags;
				OFF_CTRL_ZERO: d[CZ_PROT_EN] = s.prot_en;
				OFF_STATUS:    d = s.status;
				OFF_CYCLES:    d = {24'h000000, s.cycles};
				default:       r = RESP_SLVERR;
			endcase
		end
		return {r, d};
	endfunction

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [1:0]  cp;
		logic [1:0]  iop;
		logic [31:0] lim;
		logic        acc;
		logic [32:0] last;
		logic [31:0] mag;
		logic [7:0]  lg;
		logic [7:0]  base;
		logic [7:0]  vec;
		logic [7:0]  cyc;
		logic        lock;
		logic        zf;
		logic [31:0] nfl;
		logic        npe;
		logic [33:0] rd;
		pcf_req_t    rq;
		st_next = st_reg;
		go = clk_en && st_reg.ctrl.start && st_reg.phase == ST_IDLE;
		rq = st_reg.req;
		cp = st_reg.prot_en ? st_reg.ctrl.cur_priv : 2'h0;
		iop = st_reg.flags[FL_IO_PRIVILEGE_FIELD_LSB +: 2];
		lim = st_reg.prot_en ? st_reg.limit : REAL_LIMIT;
		acc = st_reg.prot_en ? rq.acc_ok : 1'b1;
		last = {1'b0, st_reg.offs} + {29'h00000000, rq.size_m1};
		mag = st_reg.opnd[31] ? (~st_reg.opnd + 32'h00000001) : st_reg.opnd;
		lg = ceil_log2(mag);
		base = rq.mem ? (rq.imm ? CLK_MUL_MI : CLK_MUL_MR) : (rq.imm ? CLK_MUL_RI : CLK_MUL_RR);
		vec = VEC_NONE;
		cyc = DEF_CLKS;
		lock = 1'b0;
		zf = st_reg.status.zero_flag;
		nfl = st_reg.flags;
		npe = st_reg.prot_en;
		rd = read_reg(st_reg, s_axi_req.araddr);
		if (clk_en) begin
			st_next.exc_valid = 1'b0;
			// ---------------- write channel ----------------
			if (s_axi_req.awvalid && st_reg.awready) begin
				st_next.awready = 1'b0;
				st_next.aw_got = 1'b1;
				st_next.awaddr = s_axi_req.awaddr[7:0];
				st_next.aw_hi_ok = (s_axi_req.awaddr[31:8] == 24'h000000);
			end
			if (s_axi_req.wvalid && st_reg.wready) begin
				st_next.wready = 1'b0;
				st_next.w_got = 1'b1;
				st_next.wdata = s_axi_req.wdata;
				st_next.wstrb = s_axi_req.wstrb;
			end
			if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
				st_next.bvalid = 1'b1;
				st_next.bresp = RESP_OKAY;
				if (!st_reg.aw_hi_ok) begin
					st_next.bresp = RESP_SLVERR;
				end else begin
					case (st_reg.awaddr)
						OFF_CTRL: begin
							st_next.ctrl = merge_strb(st_reg.ctrl, st_reg.wdata, st_reg.wstrb);
							// start waits one cycle so evaluation sees the new privilege
							st_next.ctrl.start = st_reg.wstrb[0] && st_reg.wdata[0]
								&& st_reg.phase == ST_IDLE;
						end
						OFF_REQ:   st_next.req = merge_strb(st_reg.req, st_reg.wdata, st_reg.wstrb);
						OFF_OFFS:  st_next.offs = merge_strb(st_reg.offs, st_reg.wdata, st_reg.wstrb);
						OFF_LIMIT: st_next.limit = merge_strb(st_reg.limit, st_reg.wdata, st_reg.wstrb);
						OFF_OPND:  st_next.opnd = merge_strb(st_reg.opnd, st_reg.wdata, st_reg.wstrb);
						OFF_FLAGS: st_next.flags = merge_strb(st_reg.flags, st_reg.wdata, st_reg.wstrb);
						OFF_CTRL_ZERO, OFF_STATUS, OFF_CYCLES: st_next.bresp = RESP_OKAY;
						default:   st_next.bresp = RESP_SLVERR;
					endcase
				end
			end
			if (st_reg.bvalid && s_axi_req.bready) begin
				st_next.bvalid = 1'b0;
				st_next.aw_got = 1'b0;
				st_next.w_got = 1'b0;
				st_next.awready = 1'b1;
				st_next.wready = 1'b1;
			end
			// ---------------- read channel ----------------
			if (s_axi_req.arvalid && st_reg.arready) begin
				st_next.arready = 1'b0;
				st_next.rvalid = 1'b1;
				st_next.rresp = rd[33:32];
				st_next.rdata = rd[31:0];
			end
			if (st_reg.rvalid && s_axi_req.rready) begin
				st_next.rvalid = 1'b0;
				st_next.arready = 1'b1;
			end
			// ---------------- evaluation at start ----------------
			case (rq.op)
				OP_STORE_STATUS_WORD: begin
					cyc = CLK_STORE;
					vec = mem_check(rq.mem, rq.stack, acc, last, lim);
				end
				OP_STORE_TASK_REG: begin
					cyc = CLK_STORE;
					vec = !st_reg.prot_en ? VEC_UD : mem_check(rq.mem, rq.stack, acc, last, lim);
				end
				OP_VERIFY_READ, OP_VERIFY_WRITE: begin
					if (!st_reg.prot_en) begin
						vec = VEC_UD;
					end else begin
						if (rq.op == OP_VERIFY_READ) begin
							cyc = rq.mem ? CLK_VRD_MEM : CLK_VRD_REG;
						end else begin
							cyc = rq.mem ? CLK_VWR_MEM : CLK_VWR_REG;
						end
						lock = 1'b1;
						zf = priv_ok(cp, rq.req_priv, rq.desc_priv) && rq.present && rq.acc_ok;
					end
				end
				OP_MUL: begin
					cyc = ((lg > CLK_MUL_MIN) ? lg : CLK_MUL_MIN) + base;
					vec = mem_check(rq.mem, rq.stack, acc, last, lim);
				end
				OP_MEM_ACCESS: vec = mem_check(rq.mem, rq.stack, acc, last, lim);
				OP_SEG_LOAD: begin
					if (st_reg.prot_en) begin
						lock = 1'b1;
						if (rq.stack && (rq.req_priv != cp || rq.desc_priv != cp)) begin
							vec = VEC_GP;
						end else if (!rq.stack && !priv_ok(cp, rq.req_priv, rq.desc_priv)) begin
							vec = VEC_GP;
						end else if (!rq.present) begin
							vec = rq.stack ? VEC_SS : VEC_NP;
						end
					end
				end
				OP_FAR_XFER: begin
					if (st_reg.prot_en && rq.desc_priv > cp) begin
						vec = VEC_GP;
					end else if (st_reg.offs > lim) begin
						vec = VEC_GP;
					end
				end
				OP_PRIV0: vec = (cp != 2'h0) ? VEC_GP : VEC_NONE;
				OP_IO_CHECKED: vec = (cp > iop) ? VEC_GP : VEC_NONE;
				OP_IO_TIMED: cyc = (cp <= iop) ? IO_CLKS_LOW : IO_CLKS_HIGH;
				OP_LOAD_FLAGS: begin
					nfl = st_reg.opnd;
					if (cp > iop) begin
						nfl[FL_IF_BIT] = st_reg.flags[FL_IF_BIT];
					end
					if (cp != 2'h0) begin
						nfl[FL_IO_PRIVILEGE_FIELD_LSB +: 2] = iop;
						nfl[FL_V86_BIT] = st_reg.flags[FL_V86_BIT];
					end
				end
				OP_LOAD_STATUS_WORD: npe = st_reg.prot_en | st_reg.opnd[CZ_PROT_EN];
				OP_MOVE_CTRL_ZERO: begin
					if (cp != 2'h0) begin
						vec = VEC_GP;
					end else begin
						npe = st_reg.opnd[CZ_PROT_EN];
					end
				end
				OP_COPROC_ESCAPE: begin
					if (rq.mem && rq.stack) begin
						vec = (st_reg.offs > lim) ? VEC_SS : VEC_NONE;
					end else begin
						vec = mem_check(rq.mem, 1'b0, acc, last, lim);
					end
				end
				OP_LOCKED: begin
					lock = 1'b1;
					vec = mem_check(rq.mem, rq.stack, acc, last, lim);
				end
				default: vec = VEC_NONE;
			endcase
			// ---------------- sequencing ----------------
			case (st_reg.phase)
				ST_IDLE: begin
					if (go) begin
						st_next.ctrl.start = 1'b0;
						st_next.phase = ST_RUN;
						st_next.count = cyc - 8'h01;
						st_next.cycles = cyc;
						st_next.p_fault = (vec != VEC_NONE);
						st_next.p_vec = vec;
						st_next.p_zf = zf;
						st_next.p_flags = nfl;
						st_next.p_prot_en = npe;
						st_next.bus_lock = lock;
						st_next.status.busy = 1'b1;
						st_next.status.done = 1'b0;
						st_next.status.bus_lock = lock;
					end
				end
				ST_RUN: begin
					if (st_reg.count == 8'h00) begin
						st_next.phase = ST_IDLE;
						st_next.bus_lock = 1'b0;
						st_next.status.bus_lock = 1'b0;
						st_next.status.busy = 1'b0;
						st_next.status.done = 1'b1;
						st_next.status.fault = st_reg.p_fault;
						st_next.status.vector = st_reg.p_vec;
						st_next.exc_valid = st_reg.p_fault;
						st_next.exc_vector = st_reg.p_vec;
						if (!st_reg.p_fault) begin
							st_next.flags = st_reg.p_flags;
							st_next.prot_en = st_reg.p_prot_en;
							st_next.status.zero_flag = st_reg.p_zf;
						end
					end else begin
						st_next.count = st_reg.count - 8'h01;
					end
				end
				default: st_next.phase = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			st_reg <= '0;
			st_reg.flags <= RST_FLAGS;
			st_reg.p_flags <= RST_FLAGS;
			st_reg.awready <= 1'b1;
			st_reg.wready <= 1'b1;
			st_reg.arready <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign s_axi_rsp = '{awready: st_reg.awready, wready: st_reg.wready, bvalid: st_reg.bvalid,
		bresp: st_reg.bresp, arready: st_reg.arready, rvalid: st_reg.rvalid,
		rdata: st_reg.rdata, rresp: st_reg.rresp};
	assign bus_lock = st_reg.bus_lock;
	assign exc_valid = st_reg.exc_valid;
	assign exc_vector = st_reg.exc_vector;

	// ****************************************
	// assertions
	// ****************************************
	chk_real_prot_only: assert property (@(posedge ref_clk) disable iff (!reset_n)
		go && !st_reg.prot_en && st_reg.req.op == OP_STORE_TASK_REG |=> st_reg.p_vec == VEC_UD)
		else $error("protected-only op in real mode did not fault six");
	chk_real_data_limit: assert property (@(posedge ref_clk) disable iff (!reset_n)
		go && !st_reg.prot_en && st_reg.req.op == OP_MEM_ACCESS && st_reg.req.mem
		&& !st_reg.req.stack
		&& ({1'b0, st_reg.offs} + 33'(st_reg.req.size_m1)) > {1'b0, REAL_LIMIT}
		|=> st_reg.p_vec == VEC_GP)
		else $error("real mode data overrun did not fault thirteen");
	chk_store_status_ok: assert property (@(posedge ref_clk) disable iff (!reset_n)
		go && st_reg.req.op == OP_STORE_STATUS_WORD |=> st_reg.p_vec != VEC_UD)
		else $error("status word store raised invalid opcode");
	chk_mul_zero_count: assert property (@(posedge ref_clk) disable iff (!reset_n)
		go && st_reg.req.op == OP_MUL && st_reg.opnd == 32'h00000000 && !st_reg.req.mem
		&& !st_reg.req.imm |=> st_reg.cycles == 8'h0C)
		else $error("zero multiplier register form not twelve clocks");
	chk_mul_mem_count: assert property (@(posedge ref_clk) disable iff (!reset_n)
		go && st_reg.req.op == OP_MUL && st_reg.opnd == 32'h00000100 && st_reg.req.mem
		&& !st_reg.req.imm |=> st_reg.cycles == 8'h14)
		else $error("memory multiply by 256 not twenty clocks");
	chk_locked_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
		go && st_reg.req.op == OP_LOCKED |=> bus_lock && st_reg.status.busy)
		else $error("implicitly locked op did not raise bus lock");
	chk_desc_lock: assert property (@(posedge ref_clk) disable iff (!reset_n)
		go && st_reg.prot_en && (st_reg.req.op == OP_VERIFY_READ
		|| st_reg.req.op == OP_VERIFY_WRITE || st_reg.req.op == OP_SEG_LOAD) |=> bus_lock)
		else $error("descriptor table access without bus lock");
	chk_lock_steady: assert property (@(posedge ref_clk) disable iff (!reset_n)
		clk_en && st_reg.phase == ST_RUN && st_reg.count != 8'h00 && bus_lock |=> bus_lock)
		else $error("bus lock dropped before the locked access ended");
	chk_priv0_fault: assert property (@(posedge ref_clk) disable iff (!reset_n)
		go && st_reg.prot_en && st_reg.req.op == OP_PRIV0 && st_reg.ctrl.cur_priv != 2'h0
		|=> st_reg.p_fault && st_reg.p_vec == VEC_GP)
		else $error("privileged op above level zero did not fault");
	chk_if_guard: assert property (@(posedge ref_clk) disable iff (!reset_n)
		go && st_reg.req.op == OP_LOAD_FLAGS && st_reg.prot_en
		&& st_reg.ctrl.cur_priv > st_reg.flags[FL_IO_PRIVILEGE_FIELD_LSB +: 2]
		|=> st_reg.p_flags[FL_IF_BIT] == $past(st_reg.flags[FL_IF_BIT]))
		else $error("interrupt flag changed without io privilege");
	chk_prot_sticky: assert property (@(posedge ref_clk) disable iff (!reset_n)
		go && st_reg.req.op == OP_LOAD_STATUS_WORD && st_reg.prot_en |=> st_reg.p_prot_en)
		else $error("status word load cleared protection");
	chk_verify_zf: assert property (@(posedge ref_clk) disable iff (!reset_n)
		go && st_reg.prot_en && st_reg.req.op == OP_VERIFY_WRITE
		&& (st_reg.req.desc_priv < st_reg.req.req_priv
		|| st_reg.req.desc_priv < st_reg.ctrl.cur_priv)
		|=> !st_reg.p_fault && !st_reg.p_zf)
		else $error("verify privilege failure faulted or set zero flag");
	chk_fault_no_commit: assert property (@(posedge ref_clk) disable iff (!reset_n)
		clk_en && st_reg.phase == ST_RUN && st_reg.count == 8'h00 && st_reg.p_fault
		|=> st_reg.flags == $past(st_reg.flags) && exc_valid)
		else $error("faulting op changed flags or missed event");

endmodule

// ==== verilog/pcf_pkg.sv ====
// constants, register layouts and bus carriers for the protection fault checker
// assumes an AXI4-Lite master with 32-bit data; all offsets are byte addresses
package pcf_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_REQ       = 8'h04;
	localparam logic [7:0] OFF_OFFS      = 8'h08;
	localparam logic [7:0] OFF_LIMIT     = 8'h0C;
	localparam logic [7:0] OFF_OPND      = 8'h10;
	localparam logic [7:0] OFF_FLAGS     = 8'h14;
	localparam logic [7:0] OFF_CTRL_ZERO = 8'h18;
	localparam logic [7:0] OFF_STATUS    = 8'h1C;
	localparam logic [7:0] OFF_CYCLES    = 8'h20;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// exception vectors, limits, clock counts
	// ****************************************
	localparam logic [7:0]  VEC_NONE   = 8'h00;
	localparam logic [7:0]  VEC_UD     = 8'h06;
	localparam logic [7:0]  VEC_NP     = 8'h0B;
	localparam logic [7:0]  VEC_SS     = 8'h0C;
	localparam logic [7:0]  VEC_GP     = 8'h0D;
	localparam logic [31:0] REAL_LIMIT = 32'h0000FFFF;

	localparam logic [7:0] CLK_MUL_MIN = 8'h03;
	localparam logic [7:0] CLK_MUL_RR  = 8'h09;
	localparam logic [7:0] CLK_MUL_MR  = 8'h0C;
	localparam logic [7:0] CLK_MUL_RI  = 8'h0A;
	localparam logic [7:0] CLK_MUL_MI  = 8'h0B;
	localparam logic [7:0] CLK_VRD_REG = 8'h0A;
	localparam logic [7:0] CLK_VRD_MEM = 8'h0B;
	localparam logic [7:0] CLK_VWR_REG = 8'h0F;
	localparam logic [7:0] CLK_VWR_MEM = 8'h10;
	localparam logic [7:0] CLK_STORE   = 8'h02;

	// ****************************************
	// flags and control register zero fields
	// ****************************************
	localparam int          FL_IF_BIT     = 9;
	localparam int          FL_IO_PRIVILEGE_FIELD_LSB   = 12;
	localparam int          FL_V86_BIT    = 17;
	localparam logic [31:0] RST_FLAGS     = 32'h00000002;
	localparam int          CZ_PROT_EN    = 0;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [3:0] {
		OP_STORE_STATUS_WORD, OP_STORE_TASK_REG, OP_VERIFY_READ, OP_VERIFY_WRITE,
		OP_MUL, OP_MEM_ACCESS, OP_SEG_LOAD, OP_FAR_XFER,
		OP_PRIV0, OP_IO_CHECKED, OP_IO_TIMED, OP_LOAD_FLAGS,
		OP_LOAD_STATUS_WORD, OP_MOVE_CTRL_ZERO, OP_COPROC_ESCAPE, OP_LOCKED
	} pcf_op_t;

	typedef struct packed {
		logic [28:0] rsvd;
		logic [1:0]  cur_priv;
		logic        start;
	} pcf_ctrl_t;

	typedef struct packed {
		logic [11:0] rsvd_hi;
		logic [3:0]  size_m1;
		logic [2:0]  rsvd_lo;
		logic        acc_ok;
		logic        imm;
		logic        mem;
		logic        stack;
		logic        present;
		logic [1:0]  desc_priv;
		logic [1:0]  req_priv;
		pcf_op_t     op;
	} pcf_req_t;

	typedef struct packed {
		logic [13:0] rsvd_hi;
		logic        bus_lock;
		logic        zero_flag;
		logic [7:0]  vector;
		logic [4:0]  rsvd_lo;
		logic        fault;
		logic        done;
		logic        busy;
	} pcf_status_t;

	typedef struct packed {
		logic [31:0] awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [31:0] araddr;
		logic        arvalid;
		logic        rready;
	} pcf_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} pcf_axi_rsp_t;

endpackage
